// ### design/alk_key_builder.sv
// lookup key builder: descriptor in, packed search key and entry match out
`timescale 1ns/1ps
module alk_key_builder
  import alk_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic desc_valid,
  input wire alk_variant_t desc_variant,
  input wire logic desc_first_lookup,
  input wire logic desc_group_valid,
  input wire logic [GROUP_W-1:0] desc_group,
  input wire logic [PORT_ID_W-1:0] desc_phys_port,
  input wire logic [PORT_ID_W-1:0] desc_src_port,
  input wire logic [PORT_ID_W-1:0] desc_loop_port,
  input wire logic desc_dst_inject,
  input wire logic desc_host_injected,
  input wire logic desc_from_loopback,
  input wire logic [4:0] desc_pipeline_point,
  input wire logic [2:0] desc_pipeline_action,
  input wire logic [47:0] desc_dmac,
  input wire logic [SVC_W-1:0] desc_service_index,
  input wire logic [KEY_W-1:0] desc_tail,
  output logic key_valid,
  output logic [KEY_W-1:0] key_data,
  output alk_class_t key_class,
  output logic [LEN_W-1:0] key_length,
  output logic key_hit
);
  function automatic alk_class_t variant_class(input alk_variant_t v);
    case (v)
      ipv4_vlan_key: return class_four_word;
      seven_tuple_key, custom_one_key: return class_sixteen_word;
      default: return class_eight_word;
    endcase
  endfunction

  function automatic logic [LEN_W-1:0] variant_len(input alk_variant_t v);
    case (v)
      ipv4_vlan_key: return LEN_IPV4_VLAN;
      ethertype_key: return LEN_ETHERTYPE;
      arp_key: return LEN_ARP;
      ipv4_transport_key: return LEN_IPV4_TRANSPORT;
      ipv4_misc_key: return LEN_IPV4_MISC;
      custom_two_key: return LEN_CUSTOM_TWO;
      ipv6_vlan_key: return LEN_IPV6_VLAN;
      seven_tuple_key: return LEN_SEVEN_TUPLE;
      default: return LEN_CUSTOM_ONE;
    endcase
  endfunction

  function automatic logic [3:0] eight_word_type_code(input alk_variant_t v);
    case (v)
      arp_key: return CODE8_ARP;
      ipv4_transport_key: return CODE8_IPV4_TRANSPORT;
      ipv4_misc_key: return CODE8_IPV4_MISC;
      custom_two_key: return CODE8_CUSTOM_TWO;
      ipv6_vlan_key: return CODE8_IPV6_VLAN;
      default: return CODE8_ETHERTYPE;
    endcase
  endfunction

  function automatic logic entry_word_hit(input logic [ADDR_W-1:0] a,
                                          input logic [ADDR_W-1:0] base);
    return (a[ADDR_W-1:8] == base[ADDR_W-1:8]) && (a[7] == 1'b0) && (a[1:0] == 2'b00) &&
      (a[6:2] < 5'(ENTRY_WORDS));
  endfunction

  logic [4:0] ctrl_reg;
  logic [KEY_W-1:0] entry_key_reg;
  logic [KEY_W-1:0] entry_mask_reg;
  logic [DATA_W-1:0] hit_count_reg;
  logic [DATA_W-1:0] key_count_reg;
  logic [1:0] last_mode_reg;
  logic [DATA_W-1:0] rdata_reg;

  logic s1_valid_reg;
  alk_variant_t s1_variant_reg;
  logic s1_first_reg;
  logic s1_group_valid_reg;
  logic [GROUP_W-1:0] s1_group_reg;
  logic [47:0] s1_dmac_reg;
  logic [SVC_W-1:0] s1_service_reg;
  logic [KEY_W-1:0] s1_tail_reg;
  logic [PORT_ID_W-1:0] s1_phys_reg;
  logic [PORT_ID_W-1:0] s1_src_reg;
  logic [PORT_ID_W-1:0] s1_loop_reg;
  logic s1_inject_reg;
  logic s1_host_reg;
  logic s1_loopback_reg;
  logic [4:0] s1_point_reg;
  logic [2:0] s1_action_reg;

  logic key_valid_reg;
  logic [KEY_W-1:0] key_data_reg;
  alk_class_t key_class_reg;
  logic [LEN_W-1:0] key_length_reg;
  logic key_hit_reg;

  logic [GROUP_W-1:0] port_default_group;
  logic group_write;
  logic [GROUP_W-1:0] policy_group;
  logic dest_multicast_flag;
  logic dest_broadcast_flag;
  logic service_frame_flag;
  logic [KEY_W-1:0] header;
  logic [LEN_W-1:0] header_len;
  logic [KEY_W-1:0] key_next;
  logic hit_next;

  alk_pmask_if pm();

  assign pm.phys_port = s1_phys_reg;
  assign pm.src_port = s1_src_reg;
  assign pm.loop_port = s1_loop_reg;
  assign pm.dst_inject = s1_inject_reg;
  assign pm.host_injected = s1_host_reg;
  assign pm.from_loopback = s1_loopback_reg;
  assign pm.pipeline_point = s1_point_reg;
  assign pm.pipeline_action = s1_action_reg;
  assign pm.masquerade_mask_enable = ctrl_reg[CTRL_MASQ_BIT];
  assign pm.host_inject_mask_enable = ctrl_reg[CTRL_HOST_BIT];
  assign pm.virtual_dev_mask_enable = ctrl_reg[CTRL_VDEV_BIT];
  assign pm.loopback_mode3_enable = ctrl_reg[CTRL_LBK3_BIT];

  alk_port_mask u_port_mask (
    .pm(pm.resolver)
  );

  assign group_write = reg_write && (reg_addr[ADDR_W-1:8] == OFS_GROUP_BASE[ADDR_W-1:8]);

  alk_group_mem u_group_mem (
    .clk(clk),
    .reset(reset),
    .wr_en(group_write),
    .wr_addr(reg_addr[7:2]),
    .wr_data(reg_wdata[GROUP_W-1:0]),
    .rd_addr(desc_phys_port),
    .rd_data(port_default_group)
  );

  // register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      entry_key_reg <= '0;
      entry_mask_reg <= '0;
    end else if (reg_write) begin
      if (reg_addr == OFS_CTRL) begin
        ctrl_reg <= reg_wdata[4:0];
      end
      if (entry_word_hit(reg_addr, OFS_ENTRY_KEY)) begin
        entry_key_reg[int'(reg_addr[6:2]) * DATA_W +: DATA_W] <= reg_wdata;
      end
      if (entry_word_hit(reg_addr, OFS_ENTRY_MASK)) begin
        entry_mask_reg[int'(reg_addr[6:2]) * DATA_W +: DATA_W] <= reg_wdata;
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
    end else if (reg_read) begin
      if (reg_addr == OFS_CTRL) begin
        rdata_reg <= DATA_W'(ctrl_reg);
      end else if (reg_addr == OFS_STATUS) begin
        rdata_reg <= DATA_W'({key_class_reg, 1'b0, key_hit_reg, last_mode_reg});
      end else if (reg_addr == OFS_HIT_COUNT) begin
        rdata_reg <= hit_count_reg;
      end else if (reg_addr == OFS_KEY_COUNT) begin
        rdata_reg <= key_count_reg;
      end else if (entry_word_hit(reg_addr, OFS_ENTRY_KEY)) begin
        rdata_reg <= entry_key_reg[int'(reg_addr[6:2]) * DATA_W +: DATA_W];
      end else if (entry_word_hit(reg_addr, OFS_ENTRY_MASK)) begin
        rdata_reg <= entry_mask_reg[int'(reg_addr[6:2]) * DATA_W +: DATA_W];
      end else begin
        rdata_reg <= '0;
      end
    end else begin
      rdata_reg <= '0;
    end
  end

  // stage 1 waits for the per-port table read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_valid_reg <= 1'b0;
      s1_variant_reg <= ipv4_vlan_key;
      s1_first_reg <= 1'b0;
      s1_group_valid_reg <= 1'b0;
      s1_group_reg <= '0;
      s1_dmac_reg <= '0;
      s1_service_reg <= '0;
      s1_tail_reg <= '0;
      s1_phys_reg <= '0;
      s1_src_reg <= '0;
      s1_loop_reg <= '0;
      s1_inject_reg <= 1'b0;
      s1_host_reg <= 1'b0;
      s1_loopback_reg <= 1'b0;
      s1_point_reg <= '0;
      s1_action_reg <= '0;
    end else begin
      s1_valid_reg <= desc_valid;
      s1_variant_reg <= desc_variant;
      s1_first_reg <= desc_first_lookup;
      s1_group_valid_reg <= desc_group_valid;
      s1_group_reg <= desc_group;
      s1_dmac_reg <= desc_dmac;
      s1_service_reg <= desc_service_index;
      s1_tail_reg <= desc_tail;
      s1_phys_reg <= desc_phys_port;
      s1_src_reg <= desc_src_port;
      s1_loop_reg <= desc_loop_port;
      s1_inject_reg <= desc_dst_inject;
      s1_host_reg <= desc_host_injected;
      s1_loopback_reg <= desc_from_loopback;
      s1_point_reg <= desc_pipeline_point;
      s1_action_reg <= desc_pipeline_action;
    end
  end

  always_comb begin
    policy_group = s1_group_valid_reg ? s1_group_reg : port_default_group;
    dest_multicast_flag = s1_dmac_reg[40];
    dest_broadcast_flag = &s1_dmac_reg;
    service_frame_flag = (s1_service_reg != '0);
    // last listed field lands at bit 0, each field listed before it directly above
    case (variant_class(s1_variant_reg))
      class_four_word: begin
        header = KEY_W'({policy_group, s1_first_reg});
        header_len = HDR_FOUR;
      end
      class_sixteen_word: begin
        header = KEY_W'({service_frame_flag, dest_broadcast_flag, dest_multicast_flag,
          pm.ingress_port_bitmap, pm.port_mask_mode, policy_group, s1_first_reg,
          (s1_variant_reg == seven_tuple_key) ? CODE16_SEVEN_TUPLE : CODE16_CUSTOM_ONE});
        header_len = HDR_SIXTEEN;
      end
      default: begin
        if (s1_variant_reg == ipv6_vlan_key) begin
          header = KEY_W'({policy_group, s1_first_reg, eight_word_type_code(s1_variant_reg)});
          header_len = HDR_EIGHT_SHORT;
        end else begin
          header = KEY_W'({service_frame_flag, dest_broadcast_flag, dest_multicast_flag,
            pm.ingress_port_bitmap, pm.port_mask_mode, policy_group, s1_first_reg,
            eight_word_type_code(s1_variant_reg)});
          header_len = HDR_EIGHT;
        end
      end
    endcase
    // bits above the variant's length are cleared so stale tail bits never match
    key_next = (header | (s1_tail_reg << header_len)) &
      ~({KEY_W{1'b1}} << variant_len(s1_variant_reg));
    hit_next = ctrl_reg[CTRL_ENTRY_BIT] &&
      (((key_next ^ entry_key_reg) & entry_mask_reg) == '0);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      key_valid_reg <= 1'b0;
      key_data_reg <= '0;
      key_class_reg <= class_four_word;
      key_length_reg <= '0;
      key_hit_reg <= 1'b0;
      last_mode_reg <= MODE_DEFAULT;
    end else begin
      key_valid_reg <= s1_valid_reg;
      if (s1_valid_reg) begin
        key_data_reg <= key_next;
        key_class_reg <= variant_class(s1_variant_reg);
        key_length_reg <= variant_len(s1_variant_reg);
        key_hit_reg <= hit_next;
        last_mode_reg <= pm.port_mask_mode;
      end
    end
  end

  // a write to a counter clears it, but a key in the same cycle still counts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hit_count_reg <= '0;
      key_count_reg <= '0;
    end else begin
      if (s1_valid_reg && hit_next) begin
        hit_count_reg <= (reg_write && reg_addr == OFS_HIT_COUNT) ? 32'h00000001 :
          hit_count_reg + 32'h00000001;
      end else if (reg_write && reg_addr == OFS_HIT_COUNT) begin
        hit_count_reg <= '0;
      end
      if (s1_valid_reg) begin
        key_count_reg <= (reg_write && reg_addr == OFS_KEY_COUNT) ? 32'h00000001 :
          key_count_reg + 32'h00000001;
      end else if (reg_write && reg_addr == OFS_KEY_COUNT) begin
        key_count_reg <= '0;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign key_valid = key_valid_reg;
  assign key_data = key_data_reg;
  assign key_class = key_class_reg;
  assign key_length = key_length_reg;
  assign key_hit = key_hit_reg;
endmodule

// ### design/alk_pkg.sv
// constants, types and helper function of the lookup key builder
package alk_pkg;
  localparam int KEY_W = 576;
  localparam int ENTRY_WORDS = 18;
  localparam int BITMAP_W = 53;
  localparam int PORT_ID_W = 6;
  localparam int GROUP_W = 8;
  localparam int SVC_W = 10;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int GROUP_DEPTH = 64;
  localparam int LEN_W = 10;

  typedef enum logic [3:0] {
    ipv4_vlan_key, ethertype_key, arp_key, ipv4_transport_key, ipv4_misc_key,
    custom_two_key, ipv6_vlan_key, seven_tuple_key, custom_one_key
  } alk_variant_t;

  typedef enum logic [1:0] {
    class_four_word, class_eight_word, class_sixteen_word
  } alk_class_t;

  localparam logic [LEN_W-1:0] LEN_IPV4_VLAN = 10'h058;
  localparam logic [LEN_W-1:0] LEN_ETHERTYPE = 10'h10F;
  localparam logic [LEN_W-1:0] LEN_ARP = 10'h0D2;
  localparam logic [LEN_W-1:0] LEN_IPV4_TRANSPORT = 10'h11B;
  localparam logic [LEN_W-1:0] LEN_IPV4_MISC = 10'h112;
  localparam logic [LEN_W-1:0] LEN_CUSTOM_TWO = 10'h11C;
  localparam logic [LEN_W-1:0] LEN_IPV6_VLAN = 10'h11C;
  localparam logic [LEN_W-1:0] LEN_SEVEN_TUPLE = 10'h237;
  localparam logic [LEN_W-1:0] LEN_CUSTOM_ONE = 10'h222;

  localparam logic [3:0] CODE8_ETHERTYPE = 4'h0;
  localparam logic [3:0] CODE8_ARP = 4'h3;
  localparam logic [3:0] CODE8_IPV4_TRANSPORT = 4'h4;
  localparam logic [3:0] CODE8_IPV4_MISC = 4'h5;
  localparam logic [3:0] CODE8_CUSTOM_TWO = 4'h8;
  localparam logic [3:0] CODE8_IPV6_VLAN = 4'h9;
  localparam logic [1:0] CODE16_SEVEN_TUPLE = 2'h1;
  localparam logic [1:0] CODE16_CUSTOM_ONE = 2'h2;

  // header widths ahead of the fields supplied by the classifier
  localparam logic [LEN_W-1:0] HDR_FOUR = 10'h009;
  localparam logic [LEN_W-1:0] HDR_EIGHT_SHORT = 10'h00D;
  localparam logic [LEN_W-1:0] HDR_EIGHT = 10'h047;
  localparam logic [LEN_W-1:0] HDR_SIXTEEN = 10'h045;

  localparam logic [1:0] MODE_DEFAULT = 2'h0;
  localparam logic [1:0] MODE_LOOPED = 2'h1;
  localparam logic [1:0] MODE_MASQUERADE = 2'h2;
  localparam logic [1:0] MODE_SPECIAL = 2'h3;

  localparam int M3_HOST_ZERO_BIT = 0;
  localparam int M3_HOST_ONE_BIT = 1;
  localparam int M3_VDEV_ZERO_BIT = 2;
  localparam int M3_VDEV_ONE_BIT = 3;
  localparam int M3_SRC_LO = 4;
  localparam int M3_POINT_LO = 44;
  localparam int M3_ACTION_LO = 49;

  localparam logic [PORT_ID_W-1:0] HOST_PORT_ZERO_ID = 6'h35;
  localparam logic [PORT_ID_W-1:0] HOST_PORT_ONE_ID = 6'h36;
  localparam logic [PORT_ID_W-1:0] VIRTUAL_DEVICE_ZERO_ID = 6'h37;
  localparam logic [PORT_ID_W-1:0] VIRTUAL_DEVICE_ONE_ID = 6'h38;
  localparam logic [2:0] INJECT_WITH_MASQUERADE = 3'h5;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_HIT_COUNT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_KEY_COUNT = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_GROUP_BASE = 12'h400;
  localparam logic [ADDR_W-1:0] OFS_ENTRY_KEY = 12'h800;
  localparam logic [ADDR_W-1:0] OFS_ENTRY_MASK = 12'h900;
  localparam int CTRL_MASQ_BIT = 0;
  localparam int CTRL_HOST_BIT = 1;
  localparam int CTRL_VDEV_BIT = 2;
  localparam int CTRL_LBK3_BIT = 3;
  localparam int CTRL_ENTRY_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  function automatic logic [BITMAP_W-1:0] port_onehot(input logic [PORT_ID_W-1:0] port);
    logic [BITMAP_W-1:0] v;
    v = '0;
    if (port < PORT_ID_W'(BITMAP_W)) begin
      v[port] = 1'b1;
    end
    return v;
  endfunction
endpackage

// ### design/alk_pmask_if.sv
// bundle between the key builder and its port-mask resolver
`timescale 1ns/1ps
interface alk_pmask_if;
  import alk_pkg::*;
  logic [PORT_ID_W-1:0] phys_port;
  logic [PORT_ID_W-1:0] src_port;
  logic [PORT_ID_W-1:0] loop_port;
  logic dst_inject;
  logic host_injected;
  logic from_loopback;
  logic [4:0] pipeline_point;
  logic [2:0] pipeline_action;
  logic masquerade_mask_enable;
  logic host_inject_mask_enable;
  logic virtual_dev_mask_enable;
  logic loopback_mode3_enable;
  logic [1:0] port_mask_mode;
  logic [BITMAP_W-1:0] ingress_port_bitmap;
  modport builder(
    output phys_port, src_port, loop_port, dst_inject, host_injected, from_loopback,
    output pipeline_point, pipeline_action, masquerade_mask_enable,
    output host_inject_mask_enable, virtual_dev_mask_enable, loopback_mode3_enable,
    input port_mask_mode, ingress_port_bitmap
  );
  modport resolver(
    input phys_port, src_port, loop_port, dst_inject, host_injected, from_loopback,
    input pipeline_point, pipeline_action, masquerade_mask_enable,
    input host_inject_mask_enable, virtual_dev_mask_enable, loopback_mode3_enable,
    output port_mask_mode, ingress_port_bitmap
  );
endinterface

// ### design/alk_port_mask.sv
// port-mask mode selection and ingress port bitmap
`timescale 1ns/1ps
module alk_port_mask
  import alk_pkg::*;
(
  alk_pmask_if.resolver pm
);
  logic masqueraded;
  logic from_vdev;
  logic special;

  always_comb begin
    masqueraded = (pm.dst_inject && (pm.src_port != pm.phys_port)) ||
      (pm.pipeline_action == INJECT_WITH_MASQUERADE);
    from_vdev = (pm.phys_port == VIRTUAL_DEVICE_ZERO_ID) ||
      (pm.phys_port == VIRTUAL_DEVICE_ONE_ID);
    special = (pm.host_injected && pm.host_inject_mask_enable) ||
      (from_vdev && pm.virtual_dev_mask_enable) ||
      (pm.from_loopback && pm.loopback_mode3_enable);
    // checked from the highest value down so the top qualifying mode wins
    if (special) begin
      pm.port_mask_mode = MODE_SPECIAL;
    end else if (masqueraded && pm.masquerade_mask_enable) begin
      pm.port_mask_mode = MODE_MASQUERADE;
    end else if (pm.from_loopback) begin
      pm.port_mask_mode = MODE_LOOPED;
    end else begin
      pm.port_mask_mode = MODE_DEFAULT;
    end
  end

  always_comb begin
    pm.ingress_port_bitmap = '0;
    case (pm.port_mask_mode)
      MODE_DEFAULT: pm.ingress_port_bitmap = port_onehot(pm.phys_port);
      MODE_LOOPED: pm.ingress_port_bitmap = port_onehot(pm.loop_port);
      MODE_MASQUERADE: pm.ingress_port_bitmap = port_onehot(pm.src_port);
      default: begin
        // bits 10..43 and the reserved top bit stay zero
        pm.ingress_port_bitmap[M3_HOST_ZERO_BIT] = (pm.phys_port == HOST_PORT_ZERO_ID);
        pm.ingress_port_bitmap[M3_HOST_ONE_BIT] = (pm.phys_port == HOST_PORT_ONE_ID);
        pm.ingress_port_bitmap[M3_VDEV_ZERO_BIT] = (pm.phys_port == VIRTUAL_DEVICE_ZERO_ID);
        pm.ingress_port_bitmap[M3_VDEV_ONE_BIT] = (pm.phys_port == VIRTUAL_DEVICE_ONE_ID);
        pm.ingress_port_bitmap[M3_SRC_LO +: PORT_ID_W] = pm.src_port;
        pm.ingress_port_bitmap[M3_POINT_LO +: 5] = pm.pipeline_point;
        pm.ingress_port_bitmap[M3_ACTION_LO +: 3] = pm.pipeline_action;
      end
    endcase
  end
endmodule

// ### design/alk_pag_mem.sv
// per-port default policy group table with registered read data
`timescale 1ns/1ps
module alk_group_mem
  import alk_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [PORT_ID_W-1:0] wr_addr,
  input wire logic [GROUP_W-1:0] wr_data,
  input wire logic [PORT_ID_W-1:0] rd_addr,
  output logic [GROUP_W-1:0] rd_data
);
  logic [GROUP_W-1:0] mem [GROUP_DEPTH];

  // the array itself has no reset, so software must load it before traffic
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ### sim/alk_key_builder_asserts.sv
// port-level assertions for the lookup key builder
`timescale 1ns/1ps
module alk_key_builder_asserts
  import alk_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic desc_valid,
  input wire alk_variant_t desc_variant,
  input wire logic desc_first_lookup,
  input wire logic [47:0] desc_dmac,
  input wire logic [SVC_W-1:0] desc_service_index,
  input wire logic key_valid,
  input wire logic [KEY_W-1:0] key_data,
  input wire alk_class_t key_class,
  input wire logic [LEN_W-1:0] key_length,
  input wire logic key_hit
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic x4, eth, x16;
  assign x4 = desc_valid && desc_variant == ipv4_vlan_key;
  assign eth = desc_valid && desc_variant == ethertype_key;
  assign x16 = desc_valid && desc_variant == seven_tuple_key;
  key_lat_a: assert property (desc_valid |-> ##2 key_valid)
    else $error("key missing two cycles after descriptor");
  key_src_a: assert property (key_valid |-> $past(desc_valid, 2))
    else $error("key without descriptor");
  rd_idle_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  x4_head_a: assert property (x4 |-> ##2 key_data[0] == $past(desc_first_lookup, 2)
    && key_class == class_four_word && key_length == 10'h058) else $error("bad x4 head");
  x4_tail_a: assert property (x4 |-> ##2 key_data[KEY_W-1:88] == '0)
    else $error("bits above x4 length");
  eth_code_a: assert property (eth |-> ##2 key_data[4:0] == {$past(desc_first_lookup, 2),
    4'h0} && key_class == class_eight_word) else $error("bad eight-word head");
  mc_flag_a: assert property (eth |-> ##2 key_data[68] == $past(desc_dmac[40], 2))
    else $error("multicast flag wrong");
  bc_flag_a: assert property (eth |-> ##2 key_data[69] == ($past(desc_dmac, 2) == '1))
    else $error("broadcast flag wrong");
  svc_flag_a: assert property (eth |-> ##2
    key_data[70] == ($past(desc_service_index, 2) != 0)) else $error("service flag wrong");
  x16_code_a: assert property (x16 |-> ##2 key_data[1:0] == 2'h1 && key_length == 10'h237)
    else $error("bad sixteen-word head");
  cover property (eth ##2 key_data[14:13] == 2'h3);
  cover property (x16 ##2 key_valid);
  cover property (key_valid && key_hit);
endmodule
bind alk_key_builder alk_key_builder_asserts i_chk (.*);

// ### sim/alk_classifier_model.sv
// classifier-side model: presents one descriptor per request
`timescale 1ns/1ps
module alk_classifier_model
  import alk_pkg::*;
(
  input wire logic clk,
  output logic desc_valid,
  output alk_variant_t desc_variant,
  output logic desc_first_lookup,
  output logic desc_group_valid,
  output logic [GROUP_W-1:0] desc_group,
  output logic [PORT_ID_W-1:0] desc_phys_port,
  output logic [PORT_ID_W-1:0] desc_src_port,
  output logic [PORT_ID_W-1:0] desc_loop_port,
  output logic desc_dst_inject,
  output logic desc_host_injected,
  output logic desc_from_loopback,
  output logic [4:0] desc_pipeline_point,
  output logic [2:0] desc_pipeline_action,
  output logic [47:0] desc_dmac,
  output logic [SVC_W-1:0] desc_service_index,
  output logic [KEY_W-1:0] desc_tail
);
  logic [91:0] f_r = '0;
  initial desc_valid = 1'b0;
  initial desc_variant = ipv4_vlan_key;
  assign {desc_phys_port, desc_src_port, desc_loop_port} = f_r[91:74];
  assign desc_pipeline_action = f_r[73:71];
  assign {desc_dst_inject, desc_host_injected, desc_from_loopback} = f_r[70:68];
  assign {desc_group_valid, desc_first_lookup, desc_group, desc_dmac, desc_service_index} = f_r[67:0];
  // pipeline point reuses the loop port's low bits to keep the request short
  assign desc_pipeline_point = f_r[78:74];
  // all ones, so any leak of tail bits past the key length shows up
  assign desc_tail = '1;
  task automatic send(input alk_variant_t v, input logic [7:0] pg, input logic [17:0] pt,
                      input logic [7:0] fl, input logic [47:0] mac, input logic [9:0] sv);
    @(posedge clk);
    desc_valid <= 1'b1;
    desc_variant <= v;
    f_r <= {pt, fl[7:5], fl[4:0], pg, mac, sv};
    @(posedge clk);
    desc_valid <= 1'b0;
    // fields mean nothing without the strobe, so they are scrambled
    f_r <= ~{pt, fl[7:5], fl[4:0], pg, mac, sv};
  endtask
endmodule

// ### sim/test_alk_key_builder.sv
// self-checking bench for the lookup key builder
`timescale 1ns/1ps
module test_alk_key_builder
  import alk_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata, rv;
  logic desc_valid, desc_first_lookup, desc_group_valid, desc_dst_inject;
  logic desc_host_injected, desc_from_loopback, key_valid, key_hit;
  alk_variant_t desc_variant;
  logic [GROUP_W-1:0] desc_group;
  logic [PORT_ID_W-1:0] desc_phys_port, desc_src_port, desc_loop_port;
  logic [4:0] desc_pipeline_point;
  logic [2:0] desc_pipeline_action;
  logic [47:0] desc_dmac;
  logic [SVC_W-1:0] desc_service_index;
  logic [KEY_W-1:0] desc_tail, key_data;
  alk_class_t key_class;
  logic [LEN_W-1:0] key_length;
  int bad_count = 0;
  int tests_run = 0;
  localparam logic [52:0] M3 = (53'h7 << 4) | (53'h9 << 44);
  alk_key_builder i_dut (.*);
  alk_classifier_model i_cls (.*);
  initial forever #10 clk = ~clk;
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ek(input alk_variant_t v, input logic [7:0] pg, input logic [17:0] pt,
                    input logic [7:0] fl, input logic [47:0] mac, input logic [9:0] sv);
    i_cls.send(v, pg, pt, fl, mac, sv);
    @(posedge clk);
    #1 chk("key_valid", key_valid, 1'b1);
  endtask
  task automatic t_regs();
    rd(OFS_CTRL, rv);
    chk("ctrl reset", rv, 0);
    rd(12'h010, rv);
    chk("unmapped", rv, 0);
    wr(OFS_CTRL, 32'h1F);
    rd(OFS_CTRL, rv);
    chk("ctrl", rv, 32'h1F);
    rd(OFS_GROUP_BASE, rv);
    chk("group table read", rv, 0);
  endtask
  task automatic t_codes();
    logic [9:0] lens [9];
    logic [3:0] cds [9];
    int p;
    lens = '{10'h058, 10'h10F, 10'h0D2, 10'h11B, 10'h112, 10'h11C, 10'h11C, 10'h237, 10'h222};
    cds = '{4'h0, 4'h0, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'h1, 4'h2};
    for (int i = 0; i < 9; i++) begin
      ek(alk_variant_t'(i), 8'h00, 18'h0, 8'h03, 48'h0, 10'h0);
      p = (i == 0) ? 0 : (i > 6) ? 2 : 4;
      chk("length", key_length, lens[i]);
      chk("class", key_class, (i == 0) ? 0 : (i > 6) ? 2 : 1);
      chk("first", key_data[p], 1'b1);
      chk("key edge", key_data[lens[i] -: 2], 2'h1);
      if (i > 0) chk("code", (i > 6) ? key_data[1:0] : key_data[3:0], cds[i]);
    end
  endtask
  task automatic tm(input logic [4:0] ctl, input logic [17:0] pt, input logic [7:0] fl,
                    input logic [1:0] md, input logic [52:0] bm);
    wr(OFS_CTRL, {27'h0, ctl});
    ek(ethertype_key, 8'h00, pt, fl, 48'h0, 10'h0);
    chk("mode", key_data[14:13], md);
    chk("bitmap", key_data[67:15], bm);
  endtask
  task automatic t_modes();
    tm(5'h00, 18'h051C9, 8'h02, 2'h0, 53'h1 << 5);
    tm(5'h00, 18'h051C9, 8'h06, 2'h1, 53'h1 << 9);
    tm(5'h01, 18'h051C9, 8'hA2, 2'h2, 53'h1 << 7);
    tm(5'h01, 18'h051C9, 8'h16, 2'h2, 53'h1 << 7);
    tm(5'h00, 18'h051C9, 8'hA2, 2'h0, 53'h1 << 5);
    tm(5'h02, 18'h051C9, 8'h0E, 2'h3, M3);
    tm(5'h04, 18'h371C9, 8'h02, 2'h3, M3 | 53'h4);
    tm(5'h08, 18'h051C9, 8'h06, 2'h3, M3);
  endtask
  task automatic t_flags();
    ek(ethertype_key, 8'h00, 18'h0, 8'h02, 48'hFFFFFFFFFFFF, 10'h000);
    chk("flags bcast", key_data[70:68], 3'h3);
    ek(ethertype_key, 8'h00, 18'h0, 8'h02, 48'h010000000000, 10'h001);
    chk("flags mcast", key_data[70:68], 3'h5);
  endtask
  task automatic t_group();
    wr(OFS_GROUP_BASE + 12'h014, 32'hA5);
    ek(ipv4_vlan_key, 8'h3C, 18'h05000, 8'h00, 48'h0, 10'h0);
    chk("group default", key_data[8:0], 9'h14A);
    ek(ipv4_vlan_key, 8'h3C, 18'h05000, 8'h03, 48'h0, 10'h0);
    chk("group given", key_data[8:0], 9'h079);
  endtask
  task automatic t_hit();
    wr(OFS_CTRL, 32'h10);
    ek(ipv4_vlan_key, 8'h00, 18'h0, 8'h03, 48'h0, 10'h0);
    chk("hit open", key_hit, 1'b1);
    wr(OFS_ENTRY_MASK, 32'h1);
    ek(ipv4_vlan_key, 8'h00, 18'h0, 8'h03, 48'h0, 10'h0);
    chk("hit first", key_hit, 1'b0);
    ek(ipv4_vlan_key, 8'h00, 18'h0, 8'h02, 48'h0, 10'h0);
    chk("hit second", key_hit, 1'b1);
  endtask
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_codes();
    t_modes();
    t_flags();
    t_group();
    t_hit();
    close_out();
  end
endmodule
